/* File: logic/sdirp_pkg.sv */
// Shared constants and types for the SDI route and power control block.
package sdirp_pkg;

   // ==========================================================================
   // Four-level strap decoding
   // ==========================================================================
   typedef enum logic [1:0] {
      SDIRP_LVL_L = 2'h0,
      SDIRP_LVL_R = 2'h1,
      SDIRP_LVL_F = 2'h2,
      SDIRP_LVL_H = 2'h3
   } sdirp_lvl_t;

   // Strap pins arrive as 8-bit samples of pin voltage, full scale equal to supply.
   localparam int STRAP_W = 8;
   localparam real STRAP_FULL_SCALE = 255.0;
   localparam real THR_LR_FRAC = 0.2;
   localparam real THR_RF_FRAC = 0.5;
   localparam real THR_FH_FRAC = 0.8;
   localparam real FLOAT_FRAC = 2.0 / 3.0;
   localparam logic [7:0] THR_LR = 8'(int'(THR_LR_FRAC * STRAP_FULL_SCALE));
   localparam logic [7:0] THR_RF = 8'(int'(THR_RF_FRAC * STRAP_FULL_SCALE));
   localparam logic [7:0] THR_FH = 8'(int'(THR_FH_FRAC * STRAP_FULL_SCALE));
   localparam logic [7:0] FLOAT_CODE = 8'(int'(FLOAT_FRAC * STRAP_FULL_SCALE));
   localparam sdirp_lvl_t LVL_RESET = SDIRP_LVL_F;
   localparam int STABLE_CYCLES = 8;
   localparam logic [3:0] STABLE_LAST = 4'(STABLE_CYCLES - 1);

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_HZ = 20_000_000;
   localparam int LOCK_TIMEOUT_US = 4500;
   localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int POR_WAIT_MS = 50;
   localparam int POR_WAIT_CYC = POR_WAIT_MS * (CLK_HZ / 1_000);

   // ==========================================================================
   // Power states
   // ==========================================================================
   typedef enum logic [2:0] {
      SDIRP_PWR_NORMAL = 3'h1,
      SDIRP_PWR_SAVE = 3'h2,
      SDIRP_PWR_DOWN = 3'h4
   } sdirp_pwr_t;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_EQIDX = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

   localparam int CTRL_IN_OVR = 0;
   localparam int CTRL_IN_LVL = 1;
   localparam int CTRL_FAN_OVR = 3;
   localparam int CTRL_FAN_LVL = 4;
   localparam int CTRL_LOOP_OVR = 6;
   localparam int CTRL_LOOP_LVL = 7;
   localparam int CTRL_STAT_SEL = 9;
   localparam int CTRL_W = 11;
   localparam logic [10:0] CTRL_RESET = 11'h000;

   localparam int EQIDX_W = 6;
   localparam logic [5:0] EQIDX_RESET = 6'h00;

   localparam int ST_IN_LVL = 0;
   localparam int ST_FAN_LVL = 2;
   localparam int ST_LOOP_LVL = 4;
   localparam int ST_MODE_LVL = 6;
   localparam int ST_LOCK = 8;
   localparam int ST_CARRIER = 9;
   localparam int ST_BYPASS = 10;
   localparam int ST_PWR = 11;
   localparam int ST_READY = 14;
   localparam int ST_DUAL = 15;

   localparam int IRQ_LOCK_UP = 0;
   localparam int IRQ_LOCK_DN = 1;
   localparam int IRQ_CD_UP = 2;
   localparam int IRQ_CD_DN = 3;
   localparam int IRQ_BYPASS = 4;
   localparam int IRQ_PDOWN = 5;
   localparam int IRQ_W = 6;
   localparam logic [5:0] IRQ_RESET = 6'h00;

   localparam logic [1:0] STAT_SEL_LOCK = 2'h0;
   localparam logic [1:0] STAT_SEL_CARRIER = 2'h1;
   localparam logic [1:0] STAT_SEL_IRQ = 2'h2;

endpackage : sdirp_pkg

/* File: logic/sdirp_strap_if.sv */
// Carrier between the top and one strap filter: raw pin sample in, level out.
`timescale 1ns/10ps
interface sdirp_strap_if;
   import sdirp_pkg::*;
   logic [7:0] code;
   sdirp_lvl_t level;
   modport filt (input code, output level);
   modport ctrl (output code, input level);
endinterface : sdirp_strap_if

/* File: logic/sdirp_strap_filt.sv */
// One four-level strap: synchroniser, threshold decoder and stability filter.
`timescale 1ns/10ps
module sdirp_strap_filt
   import sdirp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Strap carrier
   sdirp_strap_if.filt sp
);

   // ==========================================================================
   // Decoding
   // ==========================================================================
   function automatic sdirp_lvl_t lvl_of(input logic [7:0] code);
      if (code < THR_LR) begin
         return SDIRP_LVL_L;
      end else if (code < THR_RF) begin
         return SDIRP_LVL_R;
      end else if (code < THR_FH) begin
         return SDIRP_LVL_F;
      end
      return SDIRP_LVL_H;
   endfunction : lvl_of

   logic [7:0] meta_r;
   logic [7:0] code_r;
   sdirp_lvl_t cand_r;
   sdirp_lvl_t level_r;
   logic [3:0] same_r;
   sdirp_lvl_t now_lvl;

   // The pin sample comes from an unclocked converter, so it is retimed first.
   always_ff @(posedge pclk or negedge presetn) begin // RQ17
      if (!presetn) begin
         meta_r <= FLOAT_CODE;
         code_r <= FLOAT_CODE;
      end else begin
         meta_r <= sp.code;
         code_r <= meta_r;
      end
   end

   assign now_lvl = lvl_of(code_r); // RQ1

   // A level is adopted only after it has been seen unchanged for a while.
   // An open pin rests in the F band, which is also the level held at reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cand_r <= LVL_RESET; // RQ2
         level_r <= LVL_RESET; // RQ2
         same_r <= 4'h0;
      end else if (now_lvl != cand_r) begin
         cand_r <= now_lvl;
         same_r <= 4'h0;
      end else if (same_r != STABLE_LAST) begin
         same_r <= same_r + 4'h1;
      end else begin
         level_r <= cand_r; // RQ17
      end
   end

   assign sp.level = level_r;

endmodule : sdirp_strap_filt

/* File: logic/sdirp_route_ctrl.sv */
// Strap routing, override registers, bypass, power state and interrupts.
//
// Contract
// RQ1: Straps decode at 0.2, 0.5, 0.8 supply.
// RQ2: Open strap sits at two thirds, reads F.
// RQ3: Dual variant: H/F primary, R/L secondary input.
// RQ4: Override bits replace every strap routing choice; the mode strap has no override bit.
// RQ5: Single variant always routes the primary input.
// RQ6: Fan-out: H none, F/L A only, R both.
// RQ7: Loop-through output disabled in state H.
// RQ8: Recovered data fans out to three outputs.
// RQ9: No lock: bypass reclocker, stop adaptation, manual index.
// RQ10: No carrier on selected input enters power save.
// RQ11: Enable pin forces reduced power regardless of carrier.
// RQ12: Configurable by straps or management link.
// RQ13: Host waits 50 ms after power-on first.
// RQ14: Status pin shows lock, carrier or interrupt.
// RQ15: Enable low: power-down, only management stays alive.
// RQ16: Power save keeps detection; carrier returns to normal.
// RQ17: Straps synchronised and filtered before taking effect.
// RQ18: Reset clears all overrides; straps govern.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
module sdirp_route_ctrl
   import sdirp_pkg::*;
#(
   parameter int LOCK_TIMEOUT = LOCK_TIMEOUT_CYC,
   parameter int POR_WAIT = POR_WAIT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Four-level strap samples
   input wire logic [7:0] input_select_strap,
   input wire logic [7:0] fanout_select_strap,
   input wire logic [7:0] loopthru_select_strap,
   input wire logic [7:0] mode_select_strap,
   // Pins and analog indications
   input wire logic dual_input_variant,
   input wire logic enable_pin,
   input wire logic cdr_lock_raw,
   input wire logic carrier_detect_raw,
   // Routing controls
   output logic input_route_secondary,
   output logic fanout_out_a_en,
   output logic fanout_out_b_en,
   output logic loopthru_out_en,
   output logic mgmt_if_spi,
   // Reclocker and equalizer controls
   output logic reclocker_bypass,
   output logic eq_adapt_en,
   output logic [5:0] eq_index,
   // Power and status
   output logic power_save,
   output logic power_down,
   output logic status_pin_n,
   output logic irq
);

   // ==========================================================================
   // Strap filters
   // ==========================================================================
   sdirp_strap_if strap_bus[4] ();
   assign strap_bus[0].code = input_select_strap;
   assign strap_bus[1].code = fanout_select_strap;
   assign strap_bus[2].code = loopthru_select_strap;
   assign strap_bus[3].code = mode_select_strap;

   for (genvar g = 0; g < 4; g++) begin : g_strap
      sdirp_strap_filt u_filt (
         .pclk(pclk),
         .presetn(presetn),
         .sp(strap_bus[g])
      );
   end

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic [3:0] pin_meta_r;
   logic [3:0] pin_r;
   logic lock_d_r;
   logic carrier_d_r;
   logic lock_s;
   logic carrier_s;
   logic enable_s;
   logic dual_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= 4'h0;
         pin_r <= 4'h0;
      end else begin
         pin_meta_r <= {dual_input_variant, enable_pin, carrier_detect_raw, cdr_lock_raw};
         pin_r <= pin_meta_r;
      end
   end

   assign lock_s = pin_r[0];
   assign carrier_s = pin_r[1];
   assign enable_s = pin_r[2];
   assign dual_s = pin_r[3];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_d_r <= 1'b0;
         carrier_d_r <= 1'b0;
      end else begin
         lock_d_r <= lock_s;
         carrier_d_r <= carrier_s;
      end
   end

   // ==========================================================================
   // Registers
   // ==========================================================================
   logic [10:0] ctrl_r;
   logic [5:0] eqidx_r;
   logic [5:0] irq_stat_r;
   logic [5:0] irq_stat_nxt;
   logic [5:0] irq_mask_r;
   logic [5:0] irq_ev;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata;
   logic [31:0] status_word;
   logic mapped;
   logic acc_first;
   logic wr_done;
   logic ready_r;
   logic [31:0] por_cnt_r;
   sdirp_pwr_t pwr_r;
   logic bypass_r;

   assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_EQIDX) || (paddr == OFS_STATUS)
                || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
   // Each access takes one wait cycle so that read data can leave a flip-flop.
   assign acc_first = psel && penable && !pready_r;
   assign wr_done = psel && penable && pready_r && pwrite && mapped;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_IN_LVL +: 2] = strap_bus[0].level;
      status_word[ST_FAN_LVL +: 2] = strap_bus[1].level;
      status_word[ST_LOOP_LVL +: 2] = strap_bus[2].level;
      status_word[ST_MODE_LVL +: 2] = strap_bus[3].level;
      status_word[ST_LOCK] = lock_s;
      status_word[ST_CARRIER] = carrier_s;
      status_word[ST_BYPASS] = bypass_r;
      status_word[ST_PWR +: 3] = pwr_r;
      status_word[ST_READY] = ready_r;
      status_word[ST_DUAL] = dual_s;
   end

   always_comb begin
      case (paddr)
         OFS_CTRL: rdata = {21'h000000, ctrl_r};
         OFS_EQIDX: rdata = {26'h0000000, eqidx_r};
         OFS_STATUS: rdata = status_word;
         OFS_IRQ_STAT: rdata = {26'h0000000, irq_stat_r};
         OFS_IRQ_MASK: rdata = {26'h0000000, irq_mask_r};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc_first;
         pslverr_r <= acc_first && !mapped;
         prdata_r <= (acc_first && !pwrite) ? rdata : 32'h0000_0000;
      end
   end

   // The host reconfigures the input, fan-out and loop-through strap choices here at run time.
   always_ff @(posedge pclk or negedge presetn) begin // RQ12
      if (!presetn) begin
         ctrl_r <= CTRL_RESET; // RQ18
         eqidx_r <= EQIDX_RESET;
         irq_mask_r <= IRQ_RESET;
      end else if (wr_done) begin
         if (paddr == OFS_CTRL) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
         end
         if (paddr == OFS_EQIDX) begin
            eqidx_r <= pwdata[EQIDX_W-1:0];
         end
         if (paddr == OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // Writes are accepted before the ready window ends; the bit only reports it.
   always_ff @(posedge pclk or negedge presetn) begin // RQ13
      if (!presetn) begin
         por_cnt_r <= 32'h0000_0000;
         ready_r <= 1'b0;
      end else if (!ready_r) begin
         por_cnt_r <= por_cnt_r + 32'h0000_0001;
         ready_r <= (por_cnt_r == 32'(POR_WAIT - 1));
      end
   end

   // ==========================================================================
   // Effective routing
   // ==========================================================================
   sdirp_lvl_t in_lvl;
   sdirp_lvl_t fan_lvl;
   sdirp_lvl_t loop_lvl;
   logic active;

   assign in_lvl = ctrl_r[CTRL_IN_OVR] ? sdirp_lvl_t'(ctrl_r[CTRL_IN_LVL +: 2])
                 : strap_bus[0].level; // RQ4
   assign fan_lvl = ctrl_r[CTRL_FAN_OVR] ? sdirp_lvl_t'(ctrl_r[CTRL_FAN_LVL +: 2])
                  : strap_bus[1].level; // RQ4
   assign loop_lvl = ctrl_r[CTRL_LOOP_OVR] ? sdirp_lvl_t'(ctrl_r[CTRL_LOOP_LVL +: 2])
                   : strap_bus[2].level; // RQ4
   assign active = (pwr_r == SDIRP_PWR_NORMAL);

   // Each of the three outputs has its own enable, all fed from one recovered stream.
   always_ff @(posedge pclk or negedge presetn) begin // RQ8
      if (!presetn) begin
         input_route_secondary <= 1'b0;
         fanout_out_a_en <= 1'b0;
         fanout_out_b_en <= 1'b0;
         loopthru_out_en <= 1'b0;
         mgmt_if_spi <= 1'b1;
      end else begin
         // The single-input part has no selector, so the primary path is forced.
         input_route_secondary <= dual_s // RQ5
            && (in_lvl == SDIRP_LVL_R || in_lvl == SDIRP_LVL_L); // RQ3
         fanout_out_a_en <= active && (fan_lvl != SDIRP_LVL_H); // RQ6
         fanout_out_b_en <= active && (fan_lvl == SDIRP_LVL_R); // RQ6
         loopthru_out_en <= active && (loop_lvl != SDIRP_LVL_H); // RQ7
         mgmt_if_spi <= strap_bus[3].level[1]; // RQ15
      end
   end

   // ==========================================================================
   // Power state
   // ==========================================================================
   sdirp_pwr_t pwr_nxt;

   always_comb begin
      case (pwr_r)
         SDIRP_PWR_NORMAL, SDIRP_PWR_SAVE, SDIRP_PWR_DOWN: begin
            if (!enable_s) begin
               pwr_nxt = SDIRP_PWR_DOWN; // RQ11
            end else if (!carrier_s) begin
               pwr_nxt = SDIRP_PWR_SAVE; // RQ10
            end else begin
               pwr_nxt = SDIRP_PWR_NORMAL; // RQ16
            end
         end
         default: pwr_nxt = SDIRP_PWR_DOWN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= SDIRP_PWR_DOWN;
         power_save <= 1'b0;
         power_down <= 1'b1;
      end else begin
         pwr_r <= pwr_nxt;
         power_save <= (pwr_nxt == SDIRP_PWR_SAVE); // RQ10
         power_down <= (pwr_nxt == SDIRP_PWR_DOWN); // RQ15
      end
   end

   // ==========================================================================
   // Reclocker bypass
   // ==========================================================================
   logic [31:0] lock_cnt_r;

   // The wait restarts whenever carrier returns, so a slow acquisition after
   // reconnection is not mistaken for an unsupported rate.
   always_ff @(posedge pclk or negedge presetn) begin // RQ9
      if (!presetn) begin
         lock_cnt_r <= 32'h0000_0000;
         bypass_r <= 1'b0;
      end else if (lock_s || !active) begin
         lock_cnt_r <= 32'h0000_0000;
         bypass_r <= 1'b0;
      end else if (!bypass_r) begin
         lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
         bypass_r <= (lock_cnt_r == 32'(LOCK_TIMEOUT - 1));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reclocker_bypass <= 1'b0;
         eq_adapt_en <= 1'b0;
         eq_index <= EQIDX_RESET;
      end else begin
         reclocker_bypass <= bypass_r; // RQ9
         eq_adapt_en <= active && !bypass_r; // RQ9
         eq_index <= eqidx_r;
      end
   end

   // ==========================================================================
   // Interrupts and status pin
   // ==========================================================================
   always_comb begin
      irq_ev = 6'h00;
      irq_ev[IRQ_LOCK_UP] = lock_s && !lock_d_r;
      irq_ev[IRQ_LOCK_DN] = !lock_s && lock_d_r;
      irq_ev[IRQ_CD_UP] = carrier_s && !carrier_d_r;
      irq_ev[IRQ_CD_DN] = !carrier_s && carrier_d_r;
      irq_ev[IRQ_BYPASS] = bypass_r && !reclocker_bypass;
      irq_ev[IRQ_PDOWN] = (pwr_nxt == SDIRP_PWR_DOWN) && (pwr_r != SDIRP_PWR_DOWN);
   end

   // A new event in the clearing cycle survives the clear.
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_done && (paddr == OFS_IRQ_STAT)) begin
         irq_stat_nxt = irq_stat_r & ~pwdata[IRQ_W-1:0];
      end
      irq_stat_nxt = irq_stat_nxt | irq_ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin // RQ14
      if (!presetn) begin
         status_pin_n <= 1'b1;
      end else begin
         case (ctrl_r[CTRL_STAT_SEL +: 2])
            STAT_SEL_LOCK: status_pin_n <= !lock_s;
            STAT_SEL_CARRIER: status_pin_n <= !carrier_s;
            STAT_SEL_IRQ: status_pin_n <= !(|(irq_stat_nxt & irq_mask_r));
            default: status_pin_n <= 1'b1;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule : sdirp_route_ctrl

/* File: test/sdirp_route_monitor.sv */
// Port checker bound to the SDI route and power control top.
`timescale 1ns/10ps
module sdirp_route_monitor (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic dual_input_variant,
   input wire logic enable_pin,
   input wire logic carrier_detect_raw,
   // Controls
   input wire logic input_route_secondary,
   input wire logic fanout_out_a_en,
   input wire logic fanout_out_b_en,
   input wire logic loopthru_out_en,
   input wire logic reclocker_bypass,
   input wire logic eq_adapt_en,
   input wire logic power_save,
   input wire logic power_down
);
   default clocking mon_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   fan_pair_a: assert property (fanout_out_b_en |-> fanout_out_a_en)
      else $error("B without A");
   ready_wait_a: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("late ready");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("long ready");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("lone error");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("stray rdata");
   bypass_adapt_a: assert property (reclocker_bypass && $past(reclocker_bypass) |-> !eq_adapt_en)
      else $error("adapt in bypass");
   pwr_onehot_a: assert property (!(power_save && power_down))
      else $error("save and down");
   down_quiet_a: assert property (power_down && $past(power_down) |->
      !(fanout_out_a_en || fanout_out_b_en || loopthru_out_en))
      else $error("on in down");
   save_quiet_a: assert property (power_save && $past(power_save) |->
      !(fanout_out_a_en || fanout_out_b_en || loopthru_out_en))
      else $error("on in save");
   pin_down_a: assert property ((!enable_pin) [*5] |-> power_down)
      else $error("no power down");
   no_carrier_a: assert property ((enable_pin && !carrier_detect_raw) [*5] |-> power_save)
      else $error("no power save");
   single_in_a: assert property ((!dual_input_variant) [*5] |-> !input_route_secondary)
      else $error("secondary on single");

   cover property (power_save);
   cover property ($rose(reclocker_bypass));
   cover property (pready && pslverr);
endmodule : sdirp_route_monitor

bind sdirp_route_ctrl sdirp_route_monitor i_mon (.*);

/* File: test/sdirp_strap_model.sv */
// Board strap model: strapping choice to pin voltage sample.
`timescale 1ns/10ps
module sdirp_strap_model
   import sdirp_pkg::*;
(
   // Choice: bit 8 set means a custom divider whose sample is bits 7:0
   input wire logic [8:0] pick,
   // Pin sample
   output logic [7:0] code
);
   always_comb begin
      if (pick[8]) begin
         code = pick[7:0];
      end else begin
         case (pick[1:0])
            2'h0: code = 8'h00;
            2'h1: code = 8'h55;
            2'h2: code = FLOAT_CODE;
            default: code = 8'hFF;
         endcase
      end
   end
endmodule : sdirp_strap_model

/* File: test/test_sdi_route_and_power_control.sv */
// Self-checking bench for the SDI route and power control block.
`timescale 1ns/10ps
module test_sdi_route_and_power_control;
   import sdirp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [8:0] pk_in, pk_fan, pk_loop, pk_mode;
   logic [7:0] input_select_strap, fanout_select_strap, loopthru_select_strap, mode_select_strap;
   logic dual_input_variant, enable_pin, cdr_lock_raw, carrier_detect_raw;
   logic input_route_secondary, fanout_out_a_en, fanout_out_b_en, loopthru_out_en;
   logic mgmt_if_spi, reclocker_bypass, eq_adapt_en, power_save, power_down, status_pin_n, irq;
   logic [5:0] eq_index;
   int err_count = 0, compares = 0;
   always #25 pclk = ~pclk;
   sdirp_strap_model i_s0 (.pick(pk_in), .code(input_select_strap));
   sdirp_strap_model i_s1 (.pick(pk_fan), .code(fanout_select_strap));
   sdirp_strap_model i_s2 (.pick(pk_loop), .code(loopthru_select_strap));
   sdirp_strap_model i_s3 (.pick(pk_mode), .code(mode_select_strap));
   sdirp_route_ctrl #(.LOCK_TIMEOUT(20), .POR_WAIT(30)) i_dut (.*);

   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk

   task automatic chkb(input logic s, input logic x);
      chk({31'h0, s}, {31'h0, x});
   endtask : chkb

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   // Held until pready is seen high at a falling edge; answer read mid-cycle.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge pclk);
      {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      @(posedge pclk);
      {psel, penable} <= 2'b00;
      if (n >= 20) begin
         err_count++;
         conclude();
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, rv, ev);
      chkb(ev, 1'b0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0, rv, ev);
      chk(rv, x);
   endtask : rd

   task automatic t_reset();
      rd(OFS_CTRL, 32'h0);
      rd(OFS_EQIDX, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      apb(OFS_STATUS, 1'b0, 32'h0, rv, ev);
      chkb(rv[ST_READY], 1'b1);
      chk({30'h0, rv[ST_FAN_LVL +: 2]}, {30'h0, SDIRP_LVL_F});
      chkb(input_route_secondary, 1'b0);
      chkb(fanout_out_a_en, 1'b1);
      chkb(fanout_out_b_en, 1'b0);
      chkb(loopthru_out_en, 1'b1);
      apb(12'h014, 1'b0, 32'h0, rv, ev);
      chkb(ev, 1'b1);
      chk(rv, 32'h0);
   endtask : t_reset

   task automatic t_levels();
      for (int l = 0; l < 4; l++) begin
         @(posedge pclk);
         {pk_in, pk_fan, pk_loop, pk_mode} <= {4{9'(l)}};
         settle(16);
         chkb(input_route_secondary, l < 2);
         chkb(fanout_out_a_en, l != 3);
         chkb(fanout_out_b_en, l == 1);
         chkb(loopthru_out_en, l != 3);
         chkb(mgmt_if_spi, l >= 2);
      end
   endtask : t_levels

   task automatic t_thresh();
      logic [7:0] cd [6] = '{8'h32, 8'h33, 8'h7F, 8'h80, 8'hCB, 8'hCC};
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         pk_fan <= {1'b1, cd[i]};
         settle(16);
         chkb(fanout_out_a_en, i != 5);
         chkb(fanout_out_b_en, i == 1 || i == 2);
      end
   endtask : t_thresh

   task automatic t_override();
      @(posedge pclk);
      pk_fan <= 9'h3;
      settle(16);
      wr(OFS_CTRL, 32'h159);
      settle(4);
      chkb(input_route_secondary, 1'b1);
      chkb(fanout_out_b_en, 1'b1);
      chkb(loopthru_out_en, 1'b1);
      rd(OFS_CTRL, 32'h159);
      @(posedge pclk);
      dual_input_variant <= 1'b0;
      settle(6);
      chkb(input_route_secondary, 1'b0);
      @(posedge pclk);
      dual_input_variant <= 1'b1;
      wr(OFS_CTRL, 32'h0);
      settle(6);
      chkb(input_route_secondary, 1'b0);
      chkb(fanout_out_a_en, 1'b0);
      chkb(loopthru_out_en, 1'b0);
   endtask : t_override

   task automatic t_power();
      @(posedge pclk);
      pk_fan <= 9'h2;
      pk_loop <= 9'h2;
      carrier_detect_raw <= 1'b0;
      settle(16);
      chkb(power_save, 1'b1);
      chkb(fanout_out_a_en, 1'b0);
      @(posedge pclk);
      carrier_detect_raw <= 1'b1;
      settle(6);
      chkb(power_save, 1'b0);
      chkb(loopthru_out_en, 1'b1);
      @(posedge pclk);
      enable_pin <= 1'b0;
      settle(6);
      chkb(power_down, 1'b1);
      chkb(loopthru_out_en, 1'b0);
      apb(OFS_STATUS, 1'b0, 32'h0, rv, ev);
      chk({29'h0, rv[ST_PWR +: 3]}, {29'h0, SDIRP_PWR_DOWN});
      @(posedge pclk);
      enable_pin <= 1'b1;
      settle(6);
      chkb(power_down, 1'b0);
   endtask : t_power

   task automatic t_bypass();
      wr(OFS_EQIDX, 32'h2A);
      chkb(eq_adapt_en, 1'b1);
      @(posedge pclk);
      cdr_lock_raw <= 1'b0;
      settle(30);
      chkb(reclocker_bypass, 1'b1);
      chkb(eq_adapt_en, 1'b0);
      chk({26'h0, eq_index}, 32'h2A);
      @(posedge pclk);
      cdr_lock_raw <= 1'b1;
      settle(6);
      chkb(reclocker_bypass, 1'b0);
      chkb(eq_adapt_en, 1'b1);
   endtask : t_bypass

   task automatic t_irq();
      wr(OFS_CTRL, 32'h200);
      settle(2);
      chkb(status_pin_n, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_IRQ_STAT, 32'h3F);
      @(posedge pclk);
      enable_pin <= 1'b0;
      settle(6);
      apb(OFS_IRQ_STAT, 1'b0, 32'h0, rv, ev);
      chkb(rv[IRQ_PDOWN], 1'b1);
      chkb(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h3F);
      wr(OFS_CTRL, 32'h400);
      settle(2);
      chkb(irq, 1'b1);
      chkb(status_pin_n, 1'b0);
      wr(OFS_IRQ_STAT, 32'h3F);
      settle(2);
      chkb(irq, 1'b0);
      chkb(status_pin_n, 1'b1);
      rd(OFS_IRQ_STAT, 32'h0);
   endtask : t_irq

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pk_in, pk_fan, pk_loop, pk_mode} = {4{9'h2}};
      {dual_input_variant, enable_pin, cdr_lock_raw, carrier_detect_raw} = 4'hF;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle(46);
      t_reset();
      t_levels();
      t_thresh();
      t_override();
      t_power();
      t_bypass();
      t_irq();
      conclude();
   end
endmodule : test_sdi_route_and_power_control
